// file: bench/lam_oh_model.sv
// Overhead source model: frame pulses with B2 count and K1/K2 bytes.
// Assumes the bench requests one frame at a time with send.
`default_nettype none
module lam_oh_model import lam_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic send,
  input wire logic [7:0] err_in,
  input wire lam_pkg::lam_byte_t k1_in,
  input wire lam_pkg::lam_byte_t k2_in,
  output logic frame_pulse,
  output logic [7:0] b2_err_count,
  output lam_pkg::lam_byte_t k1_rx,
  output lam_pkg::lam_byte_t k2_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Frame launch
  // ****************************************
  // Outside a frame the data lines toggle, so no stale value passes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_pulse <= 1'b0;
      b2_err_count <= 8'h00;
      k1_rx <= 8'h00;
      k2_rx <= 8'h00;
    end else if (send) begin
      frame_pulse <= 1'b1;
      b2_err_count <= err_in;
      k1_rx <= k1_in;
      k2_rx <= k2_in;
    end else begin
      frame_pulse <= 1'b0;
      b2_err_count <= ~b2_err_count;
      k1_rx <= ~k1_rx;
      k2_rx <= ~k2_rx;
    end
  end
endmodule : lam_oh_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench of the line alarm monitor.
// Assumes the design files and the overhead source model are compiled first.
`default_nettype none
`include "lam_map.svh"
module tb import lam_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, reg_wr, reg_rd, frame_pulse, sf_declare, send;
  logic sd_alarm, sf_alarm, prot_change_irq;
  logic [7:0] reg_addr, b2_err_count, err_in;
  lam_byte_t reg_wdata, reg_rdata, k1_rx, k2_rx, k1_in, k2_in;
  int failures = 0;
  int compares = 0;
  int irq_cnt = 0;
  logic [23:0] reg_rows [15] = '{
    {`LAM_OFF_PER0, 16'hFFFF}, {`LAM_OFF_PER1, 16'hFFFF}, {`LAM_OFF_PER2, 16'hFFFF},
    {`LAM_OFF_SAT_LO, 16'hFFFF}, {`LAM_OFF_SAT_HI, 16'hFF0F}, {`LAM_OFF_DECL_LO, 16'hFFFF},
    {`LAM_OFF_DECL_HI, 16'hFF0F}, {`LAM_OFF_CLR_LO, 16'hFFFF}, {`LAM_OFF_CLR_HI, 16'hFF0F},
    {`LAM_OFF_FCLR_LO, 16'hFFFF}, {`LAM_OFF_FCLR_HI, 16'hFF0F}, {`LAM_OFF_K1, 16'hFF00},
    {`LAM_OFF_K2, 16'hFF00}, {`LAM_OFF_STAT, 16'hFF00}, {8'h10, 16'hFF00}};
  logic [8:0] sd_rows [12] = '{9'h004, 9'h101, 9'h100, 9'h100, 9'h100, 9'h100,
    9'h100, 9'h100, 9'h000, 9'h003, 9'h102, 9'h100};

  lam_monitor uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_pulse(frame_pulse),
    .b2_err_count(b2_err_count), .sf_declare(sf_declare), .k1_rx(k1_rx), .k2_rx(k2_rx),
    .sd_alarm(sd_alarm), .sf_alarm(sf_alarm), .prot_change_irq(prot_change_irq));
  lam_oh_model src (.clock(clock), .sys_rst(sys_rst), .send(send), .err_in(err_in), .k1_in(k1_in),
    .k2_in(k2_in), .frame_pulse(frame_pulse), .b2_err_count(b2_err_count), .k1_rx(k1_rx), .k2_rx(k2_rx));

  // ****************************************
  // Clock, irq pulse count, watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (prot_change_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    conclude();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
    @(posedge clock);
  endtask : rd
  task automatic frame(input logic [7:0] e, input lam_byte_t a, input lam_byte_t b);
    send <= 1'b1;
    err_in <= e;
    k1_in <= a;
    k2_in <= b;
    @(posedge clock);
    send <= 1'b0;
    repeat (5) @(posedge clock);
  endtask : frame
  task automatic sd_is(input logic e);
    chk("sd_alarm", {7'h00, sd_alarm}, {7'h00, e});
  endtask : sd_is
  task automatic sf_is(input logic e);
    chk("sf_alarm", {7'h00, sf_alarm}, {7'h00, e});
  endtask : sf_is
  task automatic restart();
    wr(`LAM_OFF_CTRL, 8'h00);
    wr(`LAM_OFF_CTRL, 8'h01);
  endtask : restart
  task automatic conclude();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sf_declare = 1'b0;
    send = 1'b0;
    err_in = 8'h00;
    k1_in = 8'h00;
    k2_in = 8'h00;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk("alarms", {5'h00, sd_alarm, sf_alarm, prot_change_irq}, 8'h00);
    foreach (reg_rows[i]) begin
      rd(reg_rows[i][23:16], 8'h00);
      wr(reg_rows[i][23:16], reg_rows[i][15:8]);
      rd(reg_rows[i][23:16], reg_rows[i][7:0]);
    end
    // Thresholds and period set while monitoring is off
    wr(`LAM_OFF_PER0, 8'h01);
    wr(`LAM_OFF_PER1, 8'h00);
    wr(`LAM_OFF_PER2, 8'h00);
    wr(`LAM_OFF_DECL_HI, 8'h00);
    wr(`LAM_OFF_CLR_HI, 8'h00);
    wr(`LAM_OFF_FCLR_HI, 8'h00);
    wr(`LAM_OFF_DECL_LO, 8'h05);
    wr(`LAM_OFF_CLR_LO, 8'h02);
    wr(`LAM_OFF_FCLR_LO, 8'h03);
    wr(`LAM_OFF_SAT_HI, 8'h0F);
    wr(`LAM_OFF_CTRL, 8'h01);
    foreach (sd_rows[i]) begin
      frame(sd_rows[i][7:0], 8'h00, 8'h00);
      sd_is(sd_rows[i][8]);
    end
    wr(`LAM_OFF_CTRL, 8'h00);
    sf_declare <= 1'b1;
    @(posedge clock);
    sf_declare <= 1'b0;
    repeat (3) @(posedge clock);
    sd_is(1'b0);
    sf_is(1'b1);
    wr(`LAM_OFF_CTRL, 8'h01);
    frame(8'h03, 8'h00, 8'h00);
    sd_is(1'b0);
    sf_is(1'b1);
    restart();
    frame(8'h02, 8'h00, 8'h00);
    sf_is(1'b0);
    wr(`LAM_OFF_CTRL, 8'h00);
    wr(`LAM_OFF_PER0, 8'h03);
    restart();
    frame(8'h05, 8'h00, 8'h00);
    sd_is(1'b0);
    frame(8'h00, 8'h00, 8'h00);
    sd_is(1'b0);
    frame(8'h00, 8'h00, 8'h00);
    sd_is(1'b1);
    wr(`LAM_OFF_CTRL, 8'h00);
    wr(`LAM_OFF_PER0, 8'h01);
    wr(`LAM_OFF_SAT_HI, 8'h00);
    wr(`LAM_OFF_SAT_LO, 8'h02);
    restart();
    for (int i = 0; i < 3; i++) begin
      frame(8'h08, 8'h00, 8'h00);
      sd_is(i == 2);
    end
    rd(`LAM_OFF_STAT, 8'h01);
    wr(`LAM_OFF_CTRL, 8'hFE);
    rd(`LAM_OFF_CTRL, 8'h02);
    frame(8'h00, 8'hC1, 8'h00);
    frame(8'h00, 8'hC1, 8'h00);
    frame(8'h00, 8'h5A, 8'h00);
    frame(8'h00, 8'hC1, 8'h00);
    frame(8'h00, 8'hC1, 8'h00);
    rd(`LAM_OFF_K1, 8'h00);
    frame(8'h00, 8'hC1, 8'h00);
    rd(`LAM_OFF_K1, 8'hC1);
    chk("irq_count", irq_cnt[7:0], 8'h01);
    repeat (3) frame(8'h00, 8'hC1, 8'h1E);
    rd(`LAM_OFF_K2, 8'h1E);
    chk("irq_count", irq_cnt[7:0], 8'h02);
    wr(`LAM_OFF_CTRL, 8'h00);
    repeat (3) frame(8'h00, 8'h07, 8'h1E);
    rd(`LAM_OFF_K1, 8'h07);
    chk("irq_count", irq_cnt[7:0], 8'h02);
    // Reset in mid-run clears alarms, captures and settings
    sf_declare <= 1'b1;
    @(posedge clock);
    sf_declare <= 1'b0;
    @(posedge clock);
    sf_is(1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    chk("alarms", {5'h00, sd_alarm, sf_alarm, prot_change_irq}, 8'h00);
    rd(`LAM_OFF_K1, 8'h00);
    rd(`LAM_OFF_K2, 8'h00);
    rd(`LAM_OFF_PER0, 8'h00);
    conclude();
  end
endmodule : tb
`default_nettype wire

// file: verilog/lam_kbyte_filter.sv
// Persistence filter and capture for one protection byte.
// Assumes sample pulses once per frame with rx_byte valid beside it.
`default_nettype none
`include "lam_map.svh"
module lam_kbyte_filter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sample,
  input wire lam_pkg::lam_byte_t rx_byte,
  output lam_pkg::lam_byte_t cap_byte,
  output logic load
);
  import lam_pkg::*;
  lam_byte_t cand_ff, nxt_cand, nxt_cap;
  logic [1:0] cnt_ff, nxt_cnt;
  logic nxt_load;
  // ************************************
  // Three-frame persistence
  // ************************************
  always_comb begin
    nxt_cand = cand_ff;
    nxt_cnt = cnt_ff;
    nxt_cap = cap_byte;
    nxt_load = 1'b0;
    if (sample) begin
      if (rx_byte == cap_byte) begin
        nxt_cnt = 2'h0;
      end else if (rx_byte == cand_ff && cnt_ff != 2'h0) begin
        if (cnt_ff + 2'h1 == `LAM_K_PERSIST) begin
          nxt_cap = rx_byte;
          nxt_load = 1'b1;
          nxt_cnt = 2'h0;
        end else begin
          nxt_cnt = cnt_ff + 2'h1;
        end
      end else begin
        nxt_cand = rx_byte;
        nxt_cnt = 2'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cand_ff <= `LAM_RST_BYTE;
      cnt_ff <= 2'h0;
      cap_byte <= `LAM_RST_BYTE;
      load <= 1'b0;
    end else begin
      cand_ff <= nxt_cand;
      cnt_ff <= nxt_cnt;
      cap_byte <= nxt_cap;
      load <= nxt_load;
    end
  end
  // ************************************
  // Checks
  // ************************************
  property p_persist;
    @(posedge clock) disable iff (sys_rst) load |-> $past(cnt_ff) == 2'h2 && $past(sample);
  endproperty
  a_persist: assert property (p_persist) else $error("capture without three equal frames");
endmodule : lam_kbyte_filter
`default_nettype wire

// file: verilog/lam_map.svh
// Register map and fixed values of the line alarm monitor.
// Assumes byte-wide registers on an 8-bit address.
`ifndef LAM_MAP_SVH
`define LAM_MAP_SVH
`define LAM_OFF_CTRL 8'hE0
`define LAM_OFF_STAT 8'hE1
`define LAM_OFF_FCLR_LO 8'hEA
`define LAM_OFF_FCLR_HI 8'hEB
`define LAM_OFF_PER0 8'hEC
`define LAM_OFF_PER1 8'hED
`define LAM_OFF_PER2 8'hEE
`define LAM_OFF_SAT_LO 8'hEF
`define LAM_OFF_SAT_HI 8'hF0
`define LAM_OFF_DECL_LO 8'hF1
`define LAM_OFF_DECL_HI 8'hF2
`define LAM_OFF_CLR_LO 8'hF3
`define LAM_OFF_CLR_HI 8'hF4
`define LAM_OFF_K1 8'hF5
`define LAM_OFF_K2 8'hF6
`define LAM_CTRL_SD_EN 0
`define LAM_CTRL_IRQ_EN 1
`define LAM_RST_CTRL 2'h0
`define LAM_RST_BYTE 8'h00
`define LAM_RST_THR 12'h000
`define LAM_RST_PER 24'h000000
`define LAM_SAT_OFF 12'hFFF
`define LAM_SUBTOTALS 4'h8
`define LAM_K_PERSIST 2'h3
`endif

// file: verilog/lam_monitor.sv
// Line overhead monitor: B2 degrade window, fail clearing, K1/K2 capture.
// Assumes frame-rate inputs from overhead logic on the same clock.
//
// Design decision made here: the strobed register port.
`default_nettype none
`include "lam_map.svh"
module lam_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire lam_pkg::lam_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lam_pkg::lam_byte_t reg_rdata,
  input wire logic frame_pulse,
  input wire logic [7:0] b2_err_count,
  input wire logic sf_declare,
  input wire lam_pkg::lam_byte_t k1_rx,
  input wire lam_pkg::lam_byte_t k2_rx,
  output logic sd_alarm,
  output logic sf_alarm,
  output logic prot_change_irq
);
  import lam_pkg::*;
  // ************************************
  // Declarations
  // ************************************
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [23:0] period_ff, nxt_period;
  lam_count_t sat_ff, nxt_sat, decl_ff, nxt_decl, clr_ff, nxt_clr, fclr_ff, nxt_fclr;
  lam_byte_t nxt_rdata;
  logic [23:0] frame_cnt_ff, nxt_frame_cnt;
  lam_count_t sub_ff, nxt_sub, sub_cap, ram_rdata, old_sub;
  lam_slot_t slot_ff, nxt_slot;
  logic [3:0] fill_ff, nxt_fill;
  logic [14:0] total_ff, nxt_total, new_total;
  logic [12:0] sum13;
  lam_sd_state_t state_ff, nxt_state;
  logic nxt_sd, nxt_sf, nxt_irq;
  logic en, sub_end, eval;
  lam_byte_t k1_cap, k2_cap;
  logic k1_load, k2_load;
  // ************************************
  // Register port
  // ************************************
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_period = period_ff;
    nxt_sat = sat_ff;
    nxt_decl = decl_ff;
    nxt_clr = clr_ff;
    nxt_fclr = fclr_ff;
    nxt_rdata = `LAM_RST_BYTE;
    if (reg_wr) begin
      case (reg_addr)
        `LAM_OFF_CTRL: nxt_ctrl = reg_wdata[1:0];
        `LAM_OFF_FCLR_LO: nxt_fclr[7:0] = reg_wdata;
        `LAM_OFF_FCLR_HI: nxt_fclr[11:8] = reg_wdata[3:0];
        `LAM_OFF_PER0: nxt_period[7:0] = reg_wdata;
        `LAM_OFF_PER1: nxt_period[15:8] = reg_wdata;
        `LAM_OFF_PER2: nxt_period[23:16] = reg_wdata;
        `LAM_OFF_SAT_LO: nxt_sat[7:0] = reg_wdata;
        `LAM_OFF_SAT_HI: nxt_sat[11:8] = reg_wdata[3:0];
        `LAM_OFF_DECL_LO: nxt_decl[7:0] = reg_wdata;
        `LAM_OFF_DECL_HI: nxt_decl[11:8] = reg_wdata[3:0];
        `LAM_OFF_CLR_LO: nxt_clr[7:0] = reg_wdata;
        `LAM_OFF_CLR_HI: nxt_clr[11:8] = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `LAM_OFF_CTRL: nxt_rdata = {6'h00, ctrl_ff};
        `LAM_OFF_STAT: nxt_rdata = {6'h00, sf_alarm, sd_alarm};
        `LAM_OFF_FCLR_LO: nxt_rdata = fclr_ff[7:0];
        `LAM_OFF_FCLR_HI: nxt_rdata = {4'h0, fclr_ff[11:8]};
        `LAM_OFF_PER0: nxt_rdata = period_ff[7:0];
        `LAM_OFF_PER1: nxt_rdata = period_ff[15:8];
        `LAM_OFF_PER2: nxt_rdata = period_ff[23:16];
        `LAM_OFF_SAT_LO: nxt_rdata = sat_ff[7:0];
        `LAM_OFF_SAT_HI: nxt_rdata = {4'h0, sat_ff[11:8]};
        `LAM_OFF_DECL_LO: nxt_rdata = decl_ff[7:0];
        `LAM_OFF_DECL_HI: nxt_rdata = {4'h0, decl_ff[11:8]};
        `LAM_OFF_CLR_LO: nxt_rdata = clr_ff[7:0];
        `LAM_OFF_CLR_HI: nxt_rdata = {4'h0, clr_ff[11:8]};
        `LAM_OFF_K1: nxt_rdata = k1_cap;
        `LAM_OFF_K2: nxt_rdata = k2_cap;
        default: nxt_rdata = `LAM_RST_BYTE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_ff <= `LAM_RST_CTRL;
      period_ff <= `LAM_RST_PER;
      sat_ff <= `LAM_RST_THR;
      decl_ff <= `LAM_RST_THR;
      clr_ff <= `LAM_RST_THR;
      fclr_ff <= `LAM_RST_THR;
      reg_rdata <= `LAM_RST_BYTE;
    end else begin
      ctrl_ff <= nxt_ctrl;
      period_ff <= nxt_period;
      sat_ff <= nxt_sat;
      decl_ff <= nxt_decl;
      clr_ff <= nxt_clr;
      fclr_ff <= nxt_fclr;
      reg_rdata <= nxt_rdata;
    end
  end
  // ************************************
  // Degrade window engine
  // ************************************
  always_comb begin
    en = ctrl_ff[`LAM_CTRL_SD_EN];
    sum13 = {1'b0, sub_ff} + {5'h00, b2_err_count};
    if (sat_ff != `LAM_SAT_OFF && sum13 > {1'b0, sat_ff}) begin
      sub_cap = sat_ff;
    end else if (sum13[12]) begin
      sub_cap = `LAM_SAT_OFF;
    end else begin
      sub_cap = sum13[11:0];
    end
    sub_end = frame_pulse && (frame_cnt_ff + 24'h000001 >= period_ff);
    eval = en && sub_end;
    old_sub = (fill_ff == `LAM_SUBTOTALS) ? ram_rdata : `LAM_RST_THR;
    new_total = total_ff - {3'h0, old_sub} + {3'h0, sub_cap};
    nxt_frame_cnt = frame_cnt_ff;
    nxt_sub = sub_ff;
    nxt_slot = slot_ff;
    nxt_fill = fill_ff;
    nxt_total = total_ff;
    nxt_state = state_ff;
    if (!en) begin
      nxt_frame_cnt = `LAM_RST_PER;
      nxt_sub = `LAM_RST_THR;
      nxt_slot = 3'h0;
      nxt_fill = 4'h0;
      nxt_total = 15'h0000;
      nxt_state = LAM_ST_DECL_MON;
    end else if (sub_end) begin
      nxt_frame_cnt = `LAM_RST_PER;
      nxt_sub = `LAM_RST_THR;
      nxt_slot = slot_ff + 3'h1;
      nxt_fill = (fill_ff == `LAM_SUBTOTALS) ? fill_ff : fill_ff + 4'h1;
      nxt_total = new_total;
      case (state_ff)
        LAM_ST_DECL_MON: if (new_total >= {3'h0, decl_ff}) nxt_state = LAM_ST_CLR_MON;
        LAM_ST_CLR_MON: if (new_total < {3'h0, clr_ff}) nxt_state = LAM_ST_DECL_MON;
        default: nxt_state = LAM_ST_DECL_MON;
      endcase
    end else if (frame_pulse) begin
      nxt_frame_cnt = frame_cnt_ff + 24'h000001;
      nxt_sub = sub_cap;
    end
    nxt_sd = (nxt_state == LAM_ST_CLR_MON);
    nxt_sf = sf_alarm;
    if (eval && new_total < {3'h0, fclr_ff}) nxt_sf = 1'b0;
    if (sf_declare) nxt_sf = 1'b1;
    nxt_irq = ctrl_ff[`LAM_CTRL_IRQ_EN] && (k1_load || k2_load);
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_cnt_ff <= `LAM_RST_PER;
      sub_ff <= `LAM_RST_THR;
      slot_ff <= 3'h0;
      fill_ff <= 4'h0;
      total_ff <= 15'h0000;
      state_ff <= LAM_ST_DECL_MON;
      sd_alarm <= 1'b0;
      sf_alarm <= 1'b0;
      prot_change_irq <= 1'b0;
    end else begin
      frame_cnt_ff <= nxt_frame_cnt;
      sub_ff <= nxt_sub;
      slot_ff <= nxt_slot;
      fill_ff <= nxt_fill;
      total_ff <= nxt_total;
      state_ff <= nxt_state;
      sd_alarm <= nxt_sd;
      sf_alarm <= nxt_sf;
      prot_change_irq <= nxt_irq;
    end
  end
  // ************************************
  // Subtotal store and byte filters
  // ************************************
  lam_subtotal_ram u_ram (
    .clock(clock),
    .wr_en(eval),
    .wr_addr(slot_ff),
    .wr_data(sub_cap),
    .rd_addr(slot_ff),
    .rd_data(ram_rdata)
  );
  lam_kbyte_filter u_k1 (
    .clock(clock),
    .sys_rst(sys_rst),
    .sample(frame_pulse),
    .rx_byte(k1_rx),
    .cap_byte(k1_cap),
    .load(k1_load)
  );
  lam_kbyte_filter u_k2 (
    .clock(clock),
    .sys_rst(sys_rst),
    .sample(frame_pulse),
    .rx_byte(k2_rx),
    .cap_byte(k2_cap),
    .load(k2_load)
  );
  // ************************************
  // Checks
  // ************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_sd_declare;
    eval && state_ff == LAM_ST_DECL_MON && new_total >= {3'h0, decl_ff} |=> sd_alarm;
  endproperty
  a_sd_declare: assert property (p_sd_declare) else $error("SD not declared");
  property p_sd_clear;
    eval && state_ff == LAM_ST_CLR_MON && new_total < {3'h0, clr_ff} |=> !sd_alarm;
  endproperty
  a_sd_clear: assert property (p_sd_clear) else $error("SD not cleared");
  property p_sd_hyst;
    eval && state_ff == LAM_ST_CLR_MON && new_total >= {3'h0, clr_ff} |=> sd_alarm;
  endproperty
  a_sd_hyst: assert property (p_sd_hyst) else $error("SD dropped above clear threshold");
  property p_sd_hold;
    en && !sub_end ##1 en |-> $stable(sd_alarm);
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("SD moved outside evaluation");
  property p_disable;
    !en |=> !sd_alarm && fill_ff == 4'h0 && sub_ff == `LAM_RST_THR;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not reset engine");
  property p_count;
    frame_pulse && en && !sub_end |=> frame_cnt_ff == $past(frame_cnt_ff) + 24'h000001;
  endproperty
  a_count: assert property (p_count) else $error("frame count not advanced");
  property p_fill;
    fill_ff <= `LAM_SUBTOTALS;
  endproperty
  a_fill: assert property (p_fill) else $error("window holds over eight subtotals");
  property p_sat;
    frame_pulse && en && sat_ff != `LAM_SAT_OFF |=> sub_ff <= $past(sat_ff);
  endproperty
  a_sat: assert property (p_sat) else $error("subtotal above saturation");
  property p_nosat;
    frame_pulse && en && !sub_end && sat_ff == `LAM_SAT_OFF && !sum13[12] |=> {1'b0, sub_ff} == $past(sum13);
  endproperty
  a_nosat: assert property (p_nosat) else $error("errors limited with saturation off");
  property p_sf_clear;
    eval && !sf_declare && new_total < {3'h0, fclr_ff} |=> !sf_alarm;
  endproperty
  a_sf_clear: assert property (p_sf_clear) else $error("SF not cleared");
  property p_irq;
    (k1_load || k2_load) && ctrl_ff[`LAM_CTRL_IRQ_EN] |=> prot_change_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no change interrupt");
  property p_k2_cap;
    $changed(k2_cap) |-> k2_load && k2_cap == $past(k2_rx);
  endproperty
  a_k2_cap: assert property (p_k2_cap) else $error("K2 capture changed unfiltered");
  property p_k1_order;
    k1_load |-> k1_cap == $past(k1_rx);
  endproperty
  a_k1_order: assert property (p_k1_order) else $error("K1 bit order wrong");
  property p_k1_cap;
    $changed(k1_cap) |-> k1_load && k1_cap == $past(k1_rx);
  endproperty
  a_k1_cap: assert property (p_k1_cap) else $error("K1 capture changed unfiltered");
  property p_k2_order;
    k2_load |-> k2_cap == $past(k2_rx);
  endproperty
  a_k2_order: assert property (p_k2_order) else $error("K2 bit order wrong");
  property p_irq_gate;
    prot_change_irq |-> $past(ctrl_ff[`LAM_CTRL_IRQ_EN]) && $past(k1_load || k2_load);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("change interrupt without new capture");
  property p_sf_set;
    sf_declare |=> sf_alarm;
  endproperty
  a_sf_set: assert property (p_sf_set) else $error("SF set lost to clear");
  c_declare: cover property (eval && nxt_state == LAM_ST_CLR_MON && state_ff == LAM_ST_DECL_MON);
  c_clear: cover property (eval && nxt_state == LAM_ST_DECL_MON && state_ff == LAM_ST_CLR_MON);
  c_k1_load: cover property (k1_load);
  c_sf_clear: cover property (sf_alarm ##1 !sf_alarm);
endmodule : lam_monitor
`default_nettype wire

// file: verilog/lam_pkg.sv
// Types shared by the line alarm monitor modules.
// Assumes nothing of its surroundings.
`default_nettype none
package lam_pkg;
  typedef enum logic [1:0] {
    LAM_ST_DECL_MON = 2'b01,
    LAM_ST_CLR_MON = 2'b10
  } lam_sd_state_t;
  typedef logic [11:0] lam_count_t;
  typedef logic [2:0] lam_slot_t;
  typedef logic [7:0] lam_byte_t;
endpackage : lam_pkg
`default_nettype wire

// file: verilog/lam_subtotal_ram.sv
// Eight-entry store of degrade subtotals.
// Assumes one write port and one registered read port on one clock.
`default_nettype none
module lam_subtotal_ram (
  input wire logic clock,
  input wire logic wr_en,
  input wire lam_pkg::lam_slot_t wr_addr,
  input wire lam_pkg::lam_count_t wr_data,
  input wire lam_pkg::lam_slot_t rd_addr,
  output lam_pkg::lam_count_t rd_data
);
  import lam_pkg::*;
  lam_count_t mem [0:7];
  // ************************************
  // Storage, read before write
  // ************************************
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : lam_subtotal_ram
`default_nettype wire
